// file: verilog/ttsf_pkg.sv
// Function
// - Table identifier byte is 0xEB
// - Header bit order up to service key
// - Revision: major upper nibble, set 1
// - Instance tag constant, unique per channel
// - Tags preferably follow segment order
// - Content version advances mod 32
// - Current flag always one
// - Section numbers start zero, step one
// - Last-section field holds highest number
// - Service key names the service
// - Split anywhere; shared header fields
// - Concatenated payloads rebuild the instance
// - Instance arrives gzip DEFLATE compressed
// - Gzip header holds filename field
// - Sections go on signaling channel
`default_nettype none
package ttsf_pkg;
	localparam logic [7:0]  TTSF_TABLE_ID       = 8'hEB;
	localparam logic [7:0]  TTSF_MAJOR_VERSION  = 8'h01;
	localparam int          TTSF_HDR_BYTES      = 12;
	localparam logic [11:0] TTSF_HDR_AFTER_LEN  = 12'h007;
	localparam int          TTSF_DEF_MAX_PAY    = 1012;
	localparam int          TTSF_FIFO_DEPTH     = 32;
	// Register byte addresses
	localparam logic [7:0]  TTSF_REG_CTRL       = 8'h00;
	localparam logic [7:0]  TTSF_REG_ID         = 8'h04;
	localparam logic [7:0]  TTSF_REG_INST_LEN   = 8'h08;
	localparam logic [7:0]  TTSF_REG_SECT_LEN   = 8'h0C;
	localparam logic [7:0]  TTSF_REG_STATUS     = 8'h10;
	// Field positions
	localparam int          TTSF_CTRL_START     = 0;
	localparam int          TTSF_CTRL_BUMP      = 1;
	localparam int          TTSF_ST_BUSY        = 0;
	localparam logic [31:0] TTSF_RST_ID         = 32'h0000_0010;
	localparam logic [31:0] TTSF_RST_SECT_LEN   = 32'h0000_03F4;
	localparam logic [1:0]  TTSF_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  TTSF_RESP_SLVERR    = 2'h2;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} ttsf_byte_t;
	typedef struct packed {
		logic [3:0]  minor;
		logic [7:0]  tag;
		logic [15:0] service_key;
	} ttsf_id_t;
	typedef enum logic [1:0] {
		TTSF_IDLE = 2'b00,
		TTSF_HDR  = 2'b01,
		TTSF_PAY  = 2'b11
	} ttsf_state_t;
endpackage
`default_nettype wire

// file: verilog/ttsf_fifo.sv
`default_nettype none
module ttsf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;
	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge aclk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: verilog/ttsf_framer.sv
`default_nettype none
module ttsf_framer
	import ttsf_pkg::*;
#(
	parameter int MAX_PAY = TTSF_DEF_MAX_PAY
) (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]          s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic      [31:0]         s_axi_rdata,
	output logic      [1:0]          s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Compressed instance bytes in
	input  wire ttsf_pkg::ttsf_byte_t in_byte,
	input  wire logic                in_valid,
	output logic                     in_ready,
	// Section bytes out to signaling channel
	output ttsf_pkg::ttsf_byte_t     out_byte,
	output logic                     out_valid,
	input  wire logic                out_ready
);
	ttsf_state_t state;
	ttsf_id_t    id_cfg;
	logic [15:0] inst_len;
	logic [9:0]  sect_cfg;
	logic [4:0]  content_ver;
	logic [7:0]  sect_num;
	logic [7:0]  last_sect;
	logic [9:0]  pay_len;
	logic [15:0] remaining;
	logic [3:0]  hdr_idx;
	logic [9:0]  pay_idx;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        busy;
	logic        start_req;
	logic [7:0]  hdr_byte;
	logic        pay_take;
	logic        fifo_ready;
	ttsf_byte_t  fifo_in;
	ttsf_byte_t  fifo_out;
	logic        fifo_valid;

	function automatic logic [9:0] ttsf_clip(input logic [15:0] left, input logic [9:0] cap);
		ttsf_clip = (left > {6'h00, cap}) ? cap : left[9:0];
	endfunction

	function automatic logic [7:0] ttsf_last(input logic [15:0] len, input logic [9:0] cap);
		logic [15:0] n;
		n = '0;
		if (len != 16'h0000)
			n = (len - 16'h0001) / {6'h00, cap};
		ttsf_last = n[7:0];
	endfunction

	assign busy = (state != TTSF_IDLE);

	// AXI4-Lite write path: address and data latched in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= TTSF_RESP_OKAY;
			id_cfg       <= TTSF_RST_ID[27:0];
			inst_len     <= 16'h0000;
			sect_cfg     <= TTSF_RST_SECT_LEN[9:0];
			start_req    <= 1'b0;
			content_ver  <= 5'h00;
		end else begin
			start_req <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_held && w_held) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= TTSF_RESP_OKAY;
				case (aw_addr)
					TTSF_REG_CTRL: begin
						if (w_strb[0] && w_data[TTSF_CTRL_START] && !busy)
							start_req <= 1'b1;
						if (w_strb[0] && w_data[TTSF_CTRL_BUMP] && !busy)
							content_ver <= content_ver + 5'h01;
					end
					TTSF_REG_ID: begin
						// software orders the tags
						// Identity fields frozen while a section train runs
						if (busy)
							s_axi_bresp <= TTSF_RESP_SLVERR;
						else
							id_cfg <= w_data[27:0];
					end
					TTSF_REG_INST_LEN: begin
						if (busy)
							s_axi_bresp <= TTSF_RESP_SLVERR;
						else
							inst_len <= w_data[15:0];
					end
					TTSF_REG_SECT_LEN: begin
						if (busy || w_data[9:0] == 10'h000 || w_data[9:0] > 10'(MAX_PAY))
							s_axi_bresp <= TTSF_RESP_SLVERR;
						else
							sect_cfg <= w_data[9:0];
					end
					default:
						s_axi_bresp <= TTSF_RESP_SLVERR;
				endcase
			end
		end
	end

	// AXI4-Lite read path
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= TTSF_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= TTSF_RESP_OKAY;
				case (s_axi_araddr)
					TTSF_REG_CTRL:     s_axi_rdata <= 32'h0000_0000;
					TTSF_REG_ID:       s_axi_rdata <= {4'h0, id_cfg};
					TTSF_REG_INST_LEN: s_axi_rdata <= {16'h0000, inst_len};
					TTSF_REG_SECT_LEN: s_axi_rdata <= {22'h000000, sect_cfg};
					TTSF_REG_STATUS:
						s_axi_rdata <= {3'h0, content_ver, sect_num, last_sect, 7'h00, busy};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= TTSF_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Header byte selector
	always_comb begin
		logic [11:0] slen;
		slen = TTSF_HDR_AFTER_LEN + {2'h0, pay_len};
		case (hdr_idx)
			4'h0: hdr_byte = TTSF_TABLE_ID;
			4'h1: hdr_byte = {4'b0111, slen[11:8]};
			4'h2: hdr_byte = slen[7:0];
			4'h3: hdr_byte = {TTSF_MAJOR_VERSION[3:0], id_cfg.minor};
			4'h4: hdr_byte = id_cfg.tag;
			4'h5: hdr_byte = {2'b11, content_ver, 1'b1};
			4'h6: hdr_byte = sect_num;
			4'h7: hdr_byte = last_sect;
			4'h8: hdr_byte = id_cfg.service_key[15:8];
			4'h9: hdr_byte = id_cfg.service_key[7:0];
			default: hdr_byte = 8'h00;
		endcase
	end

	// Payload passes through the FIFO so the downstream can stall the source
	assign pay_take = (state == TTSF_PAY) && fifo_valid;
	assign fifo_in  = in_byte;
	assign in_ready = fifo_ready;

	ttsf_fifo #(
		.WIDTH ($bits(ttsf_byte_t)),
		.DEPTH (TTSF_FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (in_valid),
		.in_ready  (fifo_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_valid),
		.out_ready (pay_take && (!out_valid || out_ready)),
		.out_data  (fifo_out)
	);

	// Section sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= TTSF_IDLE;
			sect_num  <= 8'h00;
			last_sect <= 8'h00;
			pay_len   <= 10'h000;
			remaining <= 16'h0000;
			hdr_idx   <= 4'h0;
			pay_idx   <= 10'h000;
			out_valid <= 1'b0;
			out_byte  <= '0;
		end else begin
			if (out_valid && out_ready)
				out_valid <= 1'b0;
			case (state)
				TTSF_IDLE: begin
					if (start_req && inst_len != 16'h0000) begin
						sect_num  <= 8'h00;
						last_sect <= ttsf_last(inst_len, sect_cfg);
						remaining <= inst_len;
						pay_len   <= ttsf_clip(inst_len, sect_cfg);
						hdr_idx   <= 4'h0;
						state     <= TTSF_HDR;
					end
				end
				TTSF_HDR: begin
					if (!out_valid || out_ready) begin
						out_valid     <= 1'b1;
						out_byte.data <= hdr_byte;
						out_byte.last <= 1'b0;
						hdr_idx       <= hdr_idx + 4'h1;
						if (hdr_idx == 4'(TTSF_HDR_BYTES - 3)) begin
							pay_idx <= 10'h000;
							state   <= TTSF_PAY;
						end
					end
				end
				TTSF_PAY: begin
					if (pay_take && (!out_valid || out_ready)) begin
						out_valid     <= 1'b1;
						out_byte.data <= fifo_out.data;
						out_byte.last <= (pay_idx == pay_len - 10'h001);
						pay_idx       <= pay_idx + 10'h001;
						if (pay_idx == pay_len - 10'h001) begin
							remaining <= remaining - {6'h00, pay_len};
							hdr_idx   <= 4'h0;
							if (sect_num == last_sect) begin
								state <= TTSF_IDLE;
							end else begin
								sect_num <= sect_num + 8'h01;
								pay_len  <= ttsf_clip(remaining - {6'h00, pay_len}, sect_cfg);
								state    <= TTSF_HDR;
							end
						end
					end
				end
				default:
					state <= TTSF_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/ttsf_framer_properties.sv
`default_nettype none
module ttsf_framer_properties
	import ttsf_pkg::*;
(
	// Clock and reset
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Register answers
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [31:0]          s_axi_rdata,
	// Section stream
	input wire ttsf_pkg::ttsf_byte_t out_byte,
	input wire logic                 out_valid,
	input wire logic                 out_ready
);
	logic [11:0] idx;
	logic [11:0] len;
	logic [7:0]  sn;
	logic [7:0]  ls;
	logic [7:0]  exp_sn;
	logic        take;
	assign take = out_valid && out_ready;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idx <= 12'h000;
		else if (take)
			idx <= out_byte.last ? 12'h000 : idx + 12'h001;
	end
	always_ff @(posedge aclk) begin
		if (take && idx == 12'h001) len[11:8] <= out_byte.data[3:0];
		if (take && idx == 12'h002) len[7:0] <= out_byte.data;
		if (take && idx == 12'h006) sn <= out_byte.data;
		if (take && idx == 12'h007) ls <= out_byte.data;
	end
	// After the last section a new instance starts again at zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			exp_sn <= 8'h00;
		else if (take && out_byte.last)
			exp_sn <= (sn == ls) ? 8'h00 : sn + 8'h01;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence held_byte;
		out_valid && $stable(out_byte);
	endsequence
	out_hold_a: assert property (out_valid && !out_ready |=> held_byte)
		else $error("section byte changed before taken");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	table_id_a: assert property (out_valid && idx == 12'h000 |-> out_byte.data == 8'hEB)
		else $error("bad first section byte");
	indicator_bits_a: assert property (out_valid && idx == 12'h001 |-> out_byte.data[7:4] == 4'h7)
		else $error("bad indicator bits");
	major_ver_a: assert property (out_valid && idx == 12'h003 |-> out_byte.data[7:4] == 4'h1)
		else $error("bad major version");
	current_flag_a: assert property (out_valid && idx == 12'h005 |-> out_byte.data[0])
		else $error("current flag low");
	sect_number_a: assert property (out_valid && idx == 12'h006 |-> out_byte.data == exp_sn)
		else $error("section number out of order");
	last_number_a: assert property (out_valid && idx == 12'h007 |-> out_byte.data >= sn)
		else $error("last section below current");
	length_a: assert property (out_valid && out_byte.last |-> idx == len + 12'h002)
		else $error("section end disagrees with length");
endmodule
bind ttsf_framer ttsf_framer_properties i_chk (
	.aclk         (aclk),
	.aresetn      (aresetn),
	.s_axi_bvalid (s_axi_bvalid),
	.s_axi_bready (s_axi_bready),
	.s_axi_bresp  (s_axi_bresp),
	.s_axi_rvalid (s_axi_rvalid),
	.s_axi_rready (s_axi_rready),
	.s_axi_rdata  (s_axi_rdata),
	.out_byte     (out_byte),
	.out_valid    (out_valid),
	.out_ready    (out_ready)
);
`default_nettype wire

// file: tb/ttsf_rx_model.sv
`default_nettype none
module ttsf_rx_model
	import ttsf_pkg::*;
(
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Section stream
	input  wire ttsf_pkg::ttsf_byte_t out_byte,
	input  wire logic                 out_valid,
	output logic                      out_ready,
	// Stall select
	input  wire logic                 slow
);
	timeunit 1ns;
	timeprecision 1ps;
	ttsf_byte_t  got[$];
	logic [7:0]  pend[$];
	logic [7:0]  inst[$];
	logic [11:0] idx = 12'h000;
	logic [11:0] len = 12'h000;
	logic [7:0]  sn;
	logic [7:0]  ls;
	logic        drop;
	logic [1:0]  tick;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			tick <= tick + 2'h1;
			out_ready <= !slow || tick == 2'h3;
		end
	end
	always @(posedge aclk) begin
		if (aresetn && out_valid && out_ready) begin
			got.push_back(out_byte);
			case (idx)
				12'h001: len[11:8] = out_byte.data[3:0];
				12'h002: len[7:0] = out_byte.data;
				12'h003: drop = out_byte.data[7:4] != 4'h1;
				12'h006: sn = out_byte.data;
				12'h007: ls = out_byte.data;
				default: ;
			endcase
			if (idx == 12'h006 && sn == 8'h00) pend = {};
			if (idx > 12'h009 && !drop) pend.push_back(out_byte.data);
			// end by length, hand on when complete
			if (idx == len + 12'h002) begin
				idx = 12'h000;
				if (sn == ls && !drop) inst = pend;
			end else
				idx = idx + 12'h001;
		end
	end
endmodule
`default_nettype wire

// file: tb/test_trigger_table_section_framer.sv
`default_nettype none
module test_trigger_table_section_framer
	import ttsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0, slow = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic        awv = 0, wv = 0, arv = 0, bready = 0, rready = 0, iv = 0;
	logic        awready, wready, arready, bvalid, rvalid, in_ready, out_valid, out_ready;
	logic [1:0]  bresp, rresp;
	ttsf_byte_t  ib = 0, ob;
	int          mismatches = 0, cmp_count = 0, p = 0;
	always #2.5 aclk = ~aclk;
	ttsf_framer i_ttsf_framer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .in_byte(ib), .in_valid(iv), .in_ready(in_ready),
		.out_byte(ob), .out_valid(out_valid), .out_ready(out_ready));
	ttsf_rx_model i_ttsf_rx_model (.aclk(aclk), .aresetn(aresetn), .out_byte(ob),
		.out_valid(out_valid), .out_ready(out_ready), .slow(slow));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awv <= 0;
			if (wready) wv <= 0;
		end while (!bvalid);
		bready <= 0;
		chk(32'(bresp), 32'(e));
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arv <= 0;
		end while (!rvalid);
		rready <= 0;
		chk(32'(rresp), 32'(er));
		chk(rdata & m, e);
		@(posedge aclk);
	endtask
	task automatic feed(input int n, input logic [7:0] b);
		int k;
		k = 0;
		ib <= '{b, 1'b0};
		iv <= 1;
		while (k < n) begin
			@(posedge aclk);
			if (in_ready) begin
				k++;
				ib <= '{8'(b + k), 1'b0};
			end
		end
		iv <= 0;
		@(posedge aclk);
	endtask
	task automatic run_chk(input int n, pl, input logic [7:0] b, input logic [4:0] v,
		input ttsf_id_t id);
		logic [79:0] h;
		int s, q, k, ns;
		ns = (n + pl - 1) / pl;
		for (k = 0; k < 4000 && i_ttsf_rx_model.got.size() < p + n + 10 * ns; k++)
			@(posedge aclk);
		for (s = 0; s < ns; s++) begin
			q = (n - s * pl < pl) ? n - s * pl : pl;
			h = {8'hEB, 4'h7, 12'(7 + q), 4'h1, id.minor, id.tag, 2'b11, v, 1'b1, 8'(s),
				8'(ns - 1), id.service_key};
			for (k = 0; k < 10 + q; k++)
				chk(32'(i_ttsf_rx_model.got[p + k]), {23'h0, k < 10 ? h[79 - 8 * k -: 8] :
					8'(b + s * pl + k - 10), k == 9 + q});
			p += 10 + q;
		end
		chk(32'(i_ttsf_rx_model.inst.size()), 32'(n));
		chk(32'(i_ttsf_rx_model.inst[0]), 32'(b));
		chk(32'(i_ttsf_rx_model.inst[n - 1]), 32'(b + 8'(n - 1)));
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(TTSF_REG_ID, '1, TTSF_RST_ID, TTSF_RESP_OKAY);
		rd(TTSF_REG_SECT_LEN, '1, TTSF_RST_SECT_LEN, TTSF_RESP_OKAY);
		rd(TTSF_REG_INST_LEN, '1, 0, TTSF_RESP_OKAY);
		rd(8'h14, 0, 0, TTSF_RESP_SLVERR);
		wr(8'h14, 1, TTSF_RESP_SLVERR);
		wr(TTSF_REG_SECT_LEN, 0, TTSF_RESP_SLVERR);
		wr(TTSF_REG_SECT_LEN, 32'(TTSF_DEF_MAX_PAY + 1), TTSF_RESP_SLVERR);
		$display("test reset_regs done");
		slow <= 1;
		wr(TTSF_REG_ID, 32'h035A_1234, TTSF_RESP_OKAY);
		wr(TTSF_REG_SECT_LEN, 12, TTSF_RESP_OKAY);
		wr(TTSF_REG_INST_LEN, 32, TTSF_RESP_OKAY);
		feed(32, 8'h40);
		chk(32'(in_ready), 0);
		wr(TTSF_REG_CTRL, 1, TTSF_RESP_OKAY);
		wr(TTSF_REG_SECT_LEN, 5, TTSF_RESP_SLVERR);
		run_chk(32, 12, 8'h40, 5'h00, 28'h35A_1234);
		rd(TTSF_REG_STATUS, 32'h00FF_FF01, 32'h0002_0200, TTSF_RESP_OKAY);
		$display("test split_run done");
		slow <= 0;
		wr(TTSF_REG_CTRL, 2, TTSF_RESP_OKAY);
		rd(TTSF_REG_STATUS, 32'h1F00_0000, 32'h0100_0000, TTSF_RESP_OKAY);
		wr(TTSF_REG_SECT_LEN, 5, TTSF_RESP_OKAY);
		wr(TTSF_REG_INST_LEN, 5, TTSF_RESP_OKAY);
		feed(5, 8'h90);
		wr(TTSF_REG_CTRL, 1, TTSF_RESP_OKAY);
		run_chk(5, 5, 8'h90, 5'h01, 28'h35A_1234);
		repeat (31) wr(TTSF_REG_CTRL, 2, TTSF_RESP_OKAY);
		rd(TTSF_REG_STATUS, 32'h1F00_0000, 0, TTSF_RESP_OKAY);
		$display("test version_wrap done");
		complete_run;
	end
	// The runs need well under a fifth of this span
	initial begin
		#200000;
		mismatches++;
		$display("wrong value at %0t: timeout", $time);
		complete_run;
	end
endmodule
`default_nettype wire
